// ===== pwm_core.v
// four-channel pwm core with enables, prescaler, scalers and apb registers
// assumes an apb master on pclk; port pins resolved outside from oe/out
// Summary of operation
// - enabled channel forces its port line output
// - disabled channel returns direction to port register
// - channel clock gated by its enable
// - prescaler stops when all channels disabled
// - clock gating changes only at clock edges
// - waveform appears at next source clock cycle
// - enable bits 3:0, upper read zero
// - 7-bit free prescaler, writable in special mode
// - scale write loads scale counter unless special no-scale-load bit set
// - scaled clock zero = A/(scale0+1)/2
// - scaled clock one = B/(scale1+1)/2
// - scale counter reloads at zero, readable
// - counter write clears and loads period, duty
// - special no-clear bit keeps counter on write
// - disabling keeps counter; software resets it
// - left-aligned period match restarts the period
// - centre-aligned counter reverses at period
// - duty match toggles the channel output
// - enabled counter resumes from held value
// - special no-period-compare bit blocks period reset
// - clock a/b divide prescaler by 1..128
// - clock select picks group or scaled clock
// - global bit selects left or centre alignment
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "pwm_regs.vh"
module pwm_core (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // mode
  input wire special_mode_flag,
  // port lines
  input wire [3:0] port_pin_in,
  output reg [3:0] port_out,
  output reg [3:0] port_oe
);
  reg [7:0] clocks_r;
  reg [7:0] polarity_r;
  reg [3:0] channel_enable;
  reg [6:0] prescale_count;
  reg [7:0] scale_reload_0;
  reg [7:0] scale_reload_1;
  reg [7:0] per_buf_r [0:3];
  reg [7:0] dty_buf_r [0:3];
  reg [7:0] control_r;
  reg [7:0] special_test_reg;
  reg [7:0] port_data_r;
  reg [7:0] port_direction_reg;
  reg [7:0] rd_nxt;
  integer i;

  wire [7:0] idx = paddr[9:2];
  wire wr = psel && penable && pwrite && pready;
  wire [7:0] wd = pwdata[7:0];
  wire center_align_select = control_r[`CTL_CENTER];
  wire no_count_clear_on_write = special_mode_flag &&
    special_test_reg[`TST_NO_CLEAR];
  wire no_period_compare = special_mode_flag &&
    special_test_reg[`TST_NO_PERIOD];
  wire no_scale_load_on_write = special_mode_flag &&
    special_test_reg[`TST_NO_SCALE];
  wire [2:0] clock_a_divider = clocks_r[`CLK_A_MSB:`CLK_A_LSB];
  wire [2:0] clock_b_divider = clocks_r[`CLK_B_MSB:`CLK_B_LSB];
  wire [3:0] chan_clock_select = polarity_r[7:4];
  wire [3:0] chan_polarity = polarity_r[3:0];
  wire any_enabled = |channel_enable;

  // prescaler: free running, held when no channel is enabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= 7'h00;
    end else begin
      if (wr && idx == `IDX_PRESCALE && special_mode_flag)
        prescale_count <= wd[6:0];
      else if (any_enabled)
        prescale_count <= prescale_count + 7'h01;
    end
  end

  // low prescale bits that must all be zero for a divide-by-2^sel tick
  function [6:0] div_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: div_mask = 7'h00;
        3'h1: div_mask = 7'h01;
        3'h2: div_mask = 7'h03;
        3'h3: div_mask = 7'h07;
        3'h4: div_mask = 7'h0f;
        3'h5: div_mask = 7'h1f;
        3'h6: div_mask = 7'h3f;
        3'h7: div_mask = 7'h7f;
        default: div_mask = 7'h00;
      endcase
    end
  endfunction

  // one tick per 2^n prescaler steps; no ticks while the prescaler rests
  wire p_tick = any_enabled;
  wire clock_a_tick = p_tick &&
    ~|(prescale_count & div_mask(clock_a_divider));
  wire clock_b_tick = p_tick &&
    ~|(prescale_count & div_mask(clock_b_divider));

  wire [7:0] scale_count_0;
  wire [7:0] scale_count_1;
  wire scaled_clock_zero;
  wire scaled_clock_one;
  pwm_scaler scaler0 (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(clock_a_tick),
    .load(wr && idx == `IDX_SCALE0 && !no_scale_load_on_write),
    .reload(idx == `IDX_SCALE0 && wr ? wd : scale_reload_0),
    .count_r(scale_count_0),
    .scaled_tick_r(scaled_clock_zero)
  );
  pwm_scaler scaler1 (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(clock_b_tick),
    .load(wr && idx == `IDX_SCALE1 && !no_scale_load_on_write),
    .reload(idx == `IDX_SCALE1 && wr ? wd : scale_reload_1),
    .count_r(scale_count_1),
    .scaled_tick_r(scaled_clock_one)
  );

  // per-channel clock choice; gating is on the single clock, so it
  // can only switch between edges and never slices a tick
  wire [3:0] group_tick = {clock_b_tick, clock_b_tick,
    clock_a_tick, clock_a_tick};
  wire [3:0] scaled_tick = {scaled_clock_one, scaled_clock_one,
    scaled_clock_zero, scaled_clock_zero};
  wire [3:0] ch_tick = (chan_clock_select & scaled_tick |
    ~chan_clock_select & group_tick) & channel_enable;

  wire [3:0] cnt_wr = {wr && idx == `IDX_CCNT3, wr && idx == `IDX_CCNT2,
    wr && idx == `IDX_CCNT1, wr && idx == `IDX_CCNT0};
  wire [7:0] ch_count [0:3];
  wire [3:0] ch_wave;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      pwm_channel u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .ch_tick(ch_tick[g]),
        .enabled(channel_enable[g]),
        .center(center_align_select),
        .polarity(chan_polarity[g]),
        .no_period(no_period_compare && !center_align_select),
        .cnt_write(cnt_wr[g]),
        .cnt_keep(no_count_clear_on_write),
        .per_buf(per_buf_r[g]),
        .dty_buf(dty_buf_r[g]),
        .count_r(ch_count[g]),
        .wave_r(ch_wave[g])
      );
    end
  endgenerate

  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clocks_r <= `RST_ZERO;
      polarity_r <= `RST_ZERO;
      channel_enable <= 4'h0;
      scale_reload_0 <= `RST_ZERO;
      scale_reload_1 <= `RST_ZERO;
      control_r <= `RST_ZERO;
      special_test_reg <= `RST_ZERO;
      port_data_r <= `RST_ZERO;
      port_direction_reg <= `RST_ZERO;
      for (i = 0; i < 4; i = i + 1) begin
        per_buf_r[i] <= `RST_ONES;
        dty_buf_r[i] <= `RST_ONES;
      end
    end else begin
      if (!special_mode_flag)
        special_test_reg <= `RST_ZERO;
      if (wr) begin
        case (idx)
          `IDX_CLOCKS: clocks_r <= wd;
          `IDX_POLARITY: polarity_r <= wd;
          `IDX_ENABLE: channel_enable <= wd[3:0];
          `IDX_SCALE0: scale_reload_0 <= wd;
          `IDX_SCALE1: scale_reload_1 <= wd;
          `IDX_CONTROL: control_r <= wd & `CTL_MASK;
          `IDX_TEST: begin
            if (special_mode_flag)
              special_test_reg <= wd & `TEST_MASK;
          end
          `IDX_PORT_DATA: port_data_r <= wd;
          `IDX_PORT_DIR: port_direction_reg <= wd;
          `IDX_PER0: per_buf_r[0] <= wd;
          `IDX_PER1: per_buf_r[1] <= wd;
          `IDX_PER2: per_buf_r[2] <= wd;
          `IDX_PER3: per_buf_r[3] <= wd;
          `IDX_DTY0: dty_buf_r[0] <= wd;
          `IDX_DTY1: dty_buf_r[1] <= wd;
          `IDX_DTY2: dty_buf_r[2] <= wd;
          `IDX_DTY3: dty_buf_r[3] <= wd;
          default: ;
        endcase
      end
    end
  end

  // read mux
  always @* begin
    rd_nxt = `RST_ZERO;
    case (idx)
      `IDX_CLOCKS: rd_nxt = clocks_r;
      `IDX_POLARITY: rd_nxt = polarity_r;
      `IDX_ENABLE: rd_nxt = {4'h0, channel_enable};
      `IDX_PRESCALE: rd_nxt = {1'b0, prescale_count};
      `IDX_SCALE0: rd_nxt = scale_reload_0;
      `IDX_SCNT0: rd_nxt = scale_count_0;
      `IDX_SCALE1: rd_nxt = scale_reload_1;
      `IDX_SCNT1: rd_nxt = scale_count_1;
      `IDX_CONTROL: rd_nxt = control_r;
      `IDX_TEST: rd_nxt = special_test_reg;
      `IDX_PORT_DATA: rd_nxt = {port_data_r[7:4], port_pin_in &
        ~port_oe | port_data_r[3:0] & port_oe};
      `IDX_PORT_DIR: rd_nxt = port_direction_reg;
      `IDX_CCNT0: rd_nxt = ch_count[0];
      `IDX_CCNT1: rd_nxt = ch_count[1];
      `IDX_CCNT2: rd_nxt = ch_count[2];
      `IDX_CCNT3: rd_nxt = ch_count[3];
      `IDX_PER0: rd_nxt = per_buf_r[0];
      `IDX_PER1: rd_nxt = per_buf_r[1];
      `IDX_PER2: rd_nxt = per_buf_r[2];
      `IDX_PER3: rd_nxt = per_buf_r[3];
      `IDX_DTY0: rd_nxt = dty_buf_r[0];
      `IDX_DTY1: rd_nxt = dty_buf_r[1];
      `IDX_DTY2: rd_nxt = dty_buf_r[2];
      `IDX_DTY3: rd_nxt = dty_buf_r[3];
      default: rd_nxt = `RST_ZERO;
    endcase
  end

  wire mapped = idx >= `IDX_CLOCKS && idx <= `IDX_PORT_DIR;

  // apb answer: no wait state, registered ready and data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite)
        prdata <= {24'h000000, rd_nxt};
    end
  end

  // port pins: pwm takes precedence while enabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out <= 4'h0;
      port_oe <= 4'h0;
    end else begin
      port_oe <= channel_enable | port_direction_reg[3:0];
      port_out <= (channel_enable & ch_wave) |
        (~channel_enable & port_data_r[3:0]);
    end
  end
endmodule // pwm_core

// ===== pwm_regs.vh
// register offsets, field positions, reset values and encodings for the pwm core
// assumes the apb byte address is four times the printed register index
`ifndef PWM_REGS_VH
`define PWM_REGS_VH
// register indices as printed; apb byte address = index * 4
`define IDX_CLOCKS 8'h40
`define IDX_POLARITY 8'h41
`define IDX_ENABLE 8'h42
`define IDX_PRESCALE 8'h43
`define IDX_SCALE0 8'h44
`define IDX_SCNT0 8'h45
`define IDX_SCALE1 8'h46
`define IDX_SCNT1 8'h47
`define IDX_CCNT0 8'h48
`define IDX_CCNT1 8'h49
`define IDX_CCNT2 8'h4a
`define IDX_CCNT3 8'h4b
`define IDX_PER0 8'h4c
`define IDX_PER1 8'h4d
`define IDX_PER2 8'h4e
`define IDX_PER3 8'h4f
`define IDX_DTY0 8'h50
`define IDX_DTY1 8'h51
`define IDX_DTY2 8'h52
`define IDX_DTY3 8'h53
`define IDX_CONTROL 8'h54
`define IDX_TEST 8'h55
`define IDX_PORT_DATA 8'h56
`define IDX_PORT_DIR 8'h57
// field positions
`define CLK_A_MSB 5
`define CLK_A_LSB 3
`define CLK_B_MSB 2
`define CLK_B_LSB 0
`define CTL_CENTER 3
`define TST_NO_CLEAR 7
`define TST_NO_PERIOD 6
`define TST_NO_SCALE 5
// reset values and write masks
`define RST_ZERO 8'h00
`define RST_ONES 8'hff
`define PRESCALE_MASK 8'h7f
`define TEST_MASK 8'he0
`define CTL_MASK 8'h08
`endif

// ===== pwm_scaler.v
// one reloadable scale down-counter producing a scaled clock enable
// assumes a one-cycle source enable from the prescaler in the same clock
`timescale 1ns/1ps
`include "pwm_regs.vh"
module pwm_scaler (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire src_tick,
  input wire load,
  input wire [7:0] reload,
  // results
  output reg [7:0] count_r,
  output reg scaled_tick_r
);
  reg half_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= `RST_ZERO;
      half_r <= 1'b0;
      scaled_tick_r <= 1'b0;
    end else begin
      scaled_tick_r <= 1'b0;
      if (load) begin
        count_r <= reload;
      end else if (src_tick) begin
        if (count_r == `RST_ZERO) begin
          count_r <= reload;
          half_r <= ~half_r;
          scaled_tick_r <= half_r;
        end else begin
          count_r <= count_r - 8'h01;
        end
      end
    end
  end
endmodule // pwm_scaler

// ===== pwm_channel.v
// one 8-bit pwm channel counter with double-buffered period and duty
// assumes ch_tick is already gated by the channel enable
`timescale 1ns/1ps
`include "pwm_regs.vh"
module pwm_channel (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire ch_tick,
  input wire enabled,
  input wire center,
  input wire polarity,
  input wire no_period,
  input wire cnt_write,
  input wire cnt_keep,
  input wire [7:0] per_buf,
  input wire [7:0] dty_buf,
  // results
  output reg [7:0] count_r,
  output reg wave_r
);
  reg [7:0] per_r;
  reg [7:0] dty_r;
  reg down_r;
  wire per_hit = (count_r == per_r);
  wire dty_hit = (count_r == dty_r);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= `RST_ZERO;
      per_r <= `RST_ONES;
      dty_r <= `RST_ONES;
      down_r <= 1'b0;
      wave_r <= 1'b0;
    end else if (cnt_write) begin
      if (!cnt_keep)
        count_r <= `RST_ZERO;
      per_r <= per_buf;
      dty_r <= dty_buf;
      down_r <= 1'b0;
      wave_r <= polarity;
    end else if (!enabled) begin
      per_r <= per_buf; // counter held, not cleared
      dty_r <= dty_buf;
    end else if (ch_tick) begin
      if (!center) begin
        if (per_hit && !no_period) begin
          count_r <= `RST_ZERO;
          per_r <= per_buf;
          dty_r <= dty_buf;
          wave_r <= polarity;
        end else begin
          count_r <= count_r + 8'h01;
          if (dty_hit)
            wave_r <= ~polarity;
        end
      end else begin
        if (per_hit && !down_r) begin
          down_r <= 1'b1;
          count_r <= count_r - 8'h01;
        end else if (down_r && count_r == `RST_ZERO) begin
          down_r <= 1'b0;
          count_r <= count_r + 8'h01;
          per_r <= per_buf;
          dty_r <= dty_buf;
        end else if (down_r) begin
          count_r <= count_r - 8'h01;
        end else begin
          count_r <= count_r + 8'h01;
        end
        if (dty_hit)
          wave_r <= ~wave_r;
      end
    end
  end
endmodule // pwm_channel

// ===== port_pins.sv
// port pin model: resolves each line from core drive and board level
// assumes an undriven line settles at its ext_level bit
`timescale 1ns/1ps
module port_pins (
  // core side
  input wire [3:0] port_out,
  input wire [3:0] port_oe,
  // board side
  input wire [3:0] ext_level,
  output wire [3:0] pin
);
  assign pin = (port_oe & port_out) | (~port_oe & ext_level);
endmodule // port_pins

// ===== pwm_core_assertions.sv
// concurrent checks on the pwm core apb port and pin enables
// assumes binding onto pwm_core, everything on pclk
`timescale 1ns/1ps
module pwm_core_checker (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // mode and pins
  input wire special_mode_flag,
  input wire [3:0] port_pin_in,
  input wire [3:0] port_out,
  input wire [3:0] port_oe
);
  wire [7:0] idx = paddr[9:2];
  wire bad = idx < 8'h40 || idx > 8'h57;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence done_s; psel && penable && pready; endsequence
  AST_READY_NEXT: assert property (setup_s |=> done_s)
    else $error("ready missing after setup");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_READY_PULSE: assert property (done_s |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_MAP: assert property (done_s |-> pslverr == bad)
    else $error("error flag wrong for address");
  AST_ERR_READ_ZERO: assert property (done_s ##0 (!pwrite && bad)
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  AST_RDATA_UPPER: assert property (done_s ##0 !pwrite
    |-> prdata[31:8] == 24'h0) else $error("read upper bits set");
  AST_ENABLE_UPPER: assert property (
    done_s ##0 (!pwrite && idx == 8'h42) |-> prdata[7:4] == 4'h0)
    else $error("enable upper bits set");
  AST_PRESCALE_BIT7: assert property (
    done_s ##0 (!pwrite && idx == 8'h43) |-> !prdata[7])
    else $error("prescale bit 7 set");
  AST_OE_ON: assert property (
    done_s ##0 (pwrite && idx == 8'h42 && pwdata[0]) |=> ##[0:1] port_oe[0])
    else $error("enabled line not driven");
endmodule // pwm_core_checker
bind pwm_core pwm_core_checker pwm_core_checker_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .special_mode_flag(special_mode_flag),
  .port_pin_in(port_pin_in), .port_out(port_out), .port_oe(port_oe));

// ===== tb_top.sv
// testbench for the pwm core: apb register tasks and scenario calls
// assumes pwm_core, port_pins and the bound checker
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic special_mode_flag = 0, pv, hi, lo, over, perr;
  logic [9:0] paddr = 10'h0;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [7:0] c1, c3;
  logic [7:0] tck [4] = '{8'h00, 8'h18, 8'h00, 8'h00};
  logic [7:0] tsel [4] = '{8'h00, 8'h00, 8'h10, 8'h10};
  logic [7:0] tsc [4] = '{8'h00, 8'h00, 8'h01, 8'h04};
  logic [7:0] tdl [4] = '{8'd40, 8'd5, 8'd10, 8'd4};
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [3:0] port_pin_in, port_out, port_oe;
  int fails = 0, tests_run = 0, i, k;
  pwm_core pwm_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode_flag(special_mode_flag), .port_pin_in(port_pin_in),
    .port_out(port_out), .port_oe(port_oe));
  port_pins port_pins_i (.port_out(port_out), .port_oe(port_oe),
    .ext_level(4'h9), .pin(port_pin_in));
  initial forever #20 pclk = ~pclk;
  task complete_run;
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input [7:0] e, input [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task xfer(input [7:0] ix, input w, input [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    pv = port_out[0];
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [7:0] ix, input [7:0] d);
    xfer(ix, 1'b1, d);
  endtask
  task rd(input string n, input [7:0] ix, input [7:0] e);
    xfer(ix, 1'b0, 8'h00);
    chk(n, e, rdat[7:0]);
  endtask
  task mode(input m);
    @(posedge pclk) special_mode_flag <= m;
  endtask
  initial begin
    repeat (10000) @(posedge pclk);
    fails++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 8'h42; i <= 8'h4b; i++) rd("reset", i[7:0], 8'h00);
    rd("unmapped", 8'h30, 8'h00);
    chk("slverr", 8'h01, {7'h0, perr});
    wr(8'h42, 8'hff);
    rd("enable", 8'h42, 8'h0f);
    chk("oe on", 8'h0f, {4'h0, port_oe});
    wr(8'h42, 8'h00);
    rd("dir", 8'h57, 8'h00);
    wr(8'h57, 8'h05);
    wr(8'h42, 8'h0a);
    repeat (2) @(negedge pclk);
    chk("oe mix", 8'h0f, {4'h0, port_oe});
    wr(8'h42, 8'h00);
    repeat (2) @(negedge pclk);
    chk("oe dir", 8'h05, {4'h0, port_oe});
    wr(8'h57, 8'h00);
    xfer(8'h43, 1'b0, 8'h00);
    c1 = rdat[7:0];
    repeat (9) @(posedge pclk);
    rd("stopped", 8'h43, c1);
    wr(8'h43, 8'h33);
    rd("pres ro", 8'h43, c1);
    mode(1'b1);
    wr(8'h43, 8'hb3);
    rd("pres wr", 8'h43, 8'h33);
    wr(8'h55, 8'h20);
    wr(8'h44, 8'h09);
    rd("no load", 8'h45, 8'h00);
    wr(8'h55, 8'h00);
    mode(1'b0);
    wr(8'h44, 8'h05);
    rd("load0", 8'h45, 8'h05);
    wr(8'h46, 8'h07);
    rd("load1", 8'h47, 8'h07);
    for (i = 0; i < 4; i++) begin
      wr(8'h40, tck[i]);
      wr(8'h41, tsel[i]);
      wr(8'h44, tsc[i]);
      wr(8'h48, 8'h00);
      wr(8'h42, 8'h01);
      xfer(8'h48, 1'b0, 8'h00);
      c1 = rdat[7:0];
      repeat (37) @(posedge pclk);
      xfer(8'h48, 1'b0, 8'h00);
      wr(8'h42, 8'h00);
      chk("rate", tdl[i], rdat[7:0] - c1);
    end
    wr(8'h40, 8'h01);
    wr(8'h41, 8'h40);
    wr(8'h46, 8'h01);
    wr(8'h4a, 8'h00);
    wr(8'h42, 8'h04);
    xfer(8'h4a, 1'b0, 8'h00);
    c1 = rdat[7:0];
    repeat (37) @(posedge pclk);
    xfer(8'h4a, 1'b0, 8'h00);
    wr(8'h42, 8'h00);
    chk("rate b", 8'd5, rdat[7:0] - c1);
    xfer(8'h48, 1'b0, 8'h00);
    c3 = rdat[7:0];
    repeat (20) @(posedge pclk);
    rd("held", 8'h48, c3);
    mode(1'b1);
    wr(8'h55, 8'h80);
    wr(8'h48, 8'h00);
    rd("kept", 8'h48, c3);
    wr(8'h55, 8'h00);
    wr(8'h48, 8'h00);
    rd("cleared", 8'h48, 8'h00);
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h00);
    wr(8'h4c, 8'h03);
    wr(8'h50, 8'h01);
    for (i = 0; i < 3; i++) begin
      mode(i == 2);
      wr(8'h55, i == 2 ? 8'h40 : 8'h00);
      wr(8'h54, i == 1 ? 8'h08 : 8'h00);
      wr(8'h48, 8'h00);
      wr(8'h42, 8'h01);
      {hi, lo, over} = 3'b000;
      for (k = 0; k < 24; k++) begin
        repeat (k % 2) @(posedge pclk);
        xfer(8'h48, 1'b0, 8'h00);
        over |= rdat[7:0] > 8'h03;
        hi |= pv === 1'b1;
        lo |= pv === 1'b0;
      end
      wr(8'h42, 8'h00);
      chk("past period", {7'h0, i == 2}, {7'h0, over});
      if (i < 2) chk("toggle", 8'h01, {7'h0, hi & lo});
    end
    wr(8'h55, 8'h00);
    mode(1'b0);
    complete_run;
  end
endmodule // tb_top
